// File: design/iwt_timers.sv
// interval timer, wake-up timer and watchdog behind an axi4-lite slave
//
// What this block does
// R1: 16-bit count increments per prescaled tick while running
// R2: run clear freezes count; resume from it
// R3: on wrap load reload value, else zero
// R4: source select: aux, crystal, rc, pll ticks
// R5: prescaler divides by 1, 4, 16, 256
// R6: wrap interrupt and wake when allowed, same cycle
// R7: current count readable coherently at any time
// R8: software avoids writing count while running
// R9: software configures, loads, then sets run bit
// R10: reload is negative; interval is divisor times magnitude+1; the code gives divisor times magnitude
// R11: interval interrupt drives interrupt line 14
// R12: wake period 16 * mantissa * 2^exponent slow cycles; the code holds exponents above 12 at 12
// R13: wake expiry brings core out of halt
// R14: interrupt mode raises interrupt on rollover
// R15: reset-arm bit set-only; timeout resets system
// R16: watchdog enable set-only until reset
// R17: timeout select 2^13, 2^19, 2^22, 2^32 clocks
// R18: flag set after watchdog reset; software clears
// R19: software writes both clear words back to back
// R20: bad or misordered clear word fires watchdog
// R21: good clear or reset zeroes watchdog counter
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps

module iwt_timers #(
  parameter logic [32:0] DOG_TMO_0 = iwt_pkg::DOG_TMO_CYC_0, // shortenable timeouts
  parameter logic [32:0] DOG_TMO_1 = iwt_pkg::DOG_TMO_CYC_1,
  parameter logic [32:0] DOG_TMO_2 = iwt_pkg::DOG_TMO_CYC_2,
  parameter logic [32:0] DOG_TMO_3 = iwt_pkg::DOG_TMO_CYC_3
) (
  input  wire logic                 CORE_CLK_I,       // system clock, 100 MHz
  input  wire logic                 ARST_N_I,         // async reset, active low
  input  wire iwt_pkg::iwt_axi_req_t AXI_REQ_I,       // register bus request
  output iwt_pkg::iwt_axi_rsp_t     AXI_RSP_O,        // register bus answer
  input  wire iwt_pkg::iwt_ticks_t  TICK_SRC_I,       // interval tick source levels
  input  wire logic                 SLOW_RC_CLOCK_I,  // slow rc clock level
  input  wire logic                 DOG_RESET_CAUSE_I,// last reset came from watchdog
  output logic [31:0]               IRQ_LINES_O,      // interrupt lines to controller
  output logic                      CORE_WAKE_O,      // wake request out of halt
  output logic                      SYS_RESET_REQ_O   // watchdog system reset request
);

  iwt_pkg::iwt_state_t state_reg;  // registered state
  iwt_pkg::iwt_state_t state_next; // next state

  // decode works on word indices;
  // the two lowest address bits are ignored
  // map a byte address onto a register
  function automatic iwt_pkg::iwt_reg_t decode(input logic [iwt_pkg::AXI_AW-1:0] addr);
    logic [31:0] idx;
    idx = addr[iwt_pkg::AXI_AW-1:2];
    unique case (idx)
      iwt_pkg::IDX_WAKE:   decode = iwt_pkg::REG_WAKE;
      iwt_pkg::IDX_COUNT:  decode = iwt_pkg::REG_COUNT;
      iwt_pkg::IDX_RELOAD: decode = iwt_pkg::REG_RELOAD;
      iwt_pkg::IDX_CTL:    decode = iwt_pkg::REG_CTL;
      iwt_pkg::IDX_DOG:    decode = iwt_pkg::REG_DOG;
      iwt_pkg::IDX_KICK:   decode = iwt_pkg::REG_KICK;
      default:             decode = iwt_pkg::REG_NONE; // unmapped word
    endcase
  endfunction

  // merge write data into an old word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    merge = res;
  endfunction

  // terminal prescaler count for a divider code
  function automatic logic [7:0] presc_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: presc_last = iwt_pkg::PRESC_LAST_1;
      2'h1: presc_last = iwt_pkg::PRESC_LAST_4;
      2'h2: presc_last = iwt_pkg::PRESC_LAST_16;
      2'h3: presc_last = iwt_pkg::PRESC_LAST_256;
    endcase
  endfunction

  // combinational bus handshakes
  logic aw_ready;  // address slot free
  logic w_ready;   // data slot free
  logic ar_ready;  // read slot free
  logic aw_fire;   // address taken
  logic w_fire;    // data taken
  logic ar_fire;   // read taken
  logic wr_do;     // both halves held, write performed

  // ready while the slot is empty and no response waits
  always_comb begin
    aw_ready = ~state_reg.aw_held & ~state_reg.bvalid;
    w_ready  = ~state_reg.w_held & ~state_reg.bvalid;
    ar_ready = ~state_reg.rvalid;
    aw_fire  = AXI_REQ_I.awvalid & aw_ready;
    w_fire   = AXI_REQ_I.wvalid & w_ready;
    ar_fire  = AXI_REQ_I.arvalid & ar_ready;
    wr_do    = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
  end

  // derived timer quantities
  logic [3:0]               tick_edge;   // rising edges of tick sources
  logic                     sel_edge;    // edge of the selected source
  logic [7:0]               div_last;    // selected prescaler terminal count
  logic [3:0]               wake_exp;    // clamped exponent
  logic [iwt_pkg::WAKE_CW-1:0] wake_period; // wake period in slow cycles
  logic [32:0]              dog_tmo;     // selected timeout
  logic [31:0]              dog_last;    // last count before timeout

  // sources are sampled levels and must
  // stay below half the core rate
  // tick edge detection and period decoding
  always_comb begin
    tick_edge = TICK_SRC_I & ~state_reg.tick_prev;
    sel_edge  = tick_edge[state_reg.ctl[iwt_pkg::CTL_SRC_LO +: 2]]; // R4
    div_last  = presc_last(state_reg.ctl[iwt_pkg::CTL_DIV_LO +: 2]); // R5
    // exponents above twelve are held at twelve
    wake_exp  = (state_reg.wake_code[3:0] > iwt_pkg::WAKE_EXP_MAX) ?
                iwt_pkg::WAKE_EXP_MAX : state_reg.wake_code[3:0];
    wake_period = iwt_pkg::WAKE_CW'({state_reg.wake_code[7:4], 4'h0}) << wake_exp; // R12
    unique case (state_reg.dog_timeout_sel) // R17
      2'h0: dog_tmo = DOG_TMO_0;
      2'h1: dog_tmo = DOG_TMO_1;
      2'h2: dog_tmo = DOG_TMO_2;
      2'h3: dog_tmo = DOG_TMO_3;
    endcase
    dog_last = 32'(dog_tmo - 33'h0_0000_0001);
  end

  // next-state logic for bus, timers and watchdog
  always_comb begin
    iwt_pkg::iwt_reg_t wsel;
    iwt_pkg::iwt_reg_t rsel;
    logic [31:0]       wval;
    logic              dog_fire;
    wsel     = decode(state_reg.aw_addr);
    rsel     = decode(AXI_REQ_I.araddr);
    wval     = 32'h0000_0000;
    dog_fire = 1'b0;
    state_next = state_reg;

    // pulses last one cycle
    state_next.irq_interval = 1'b0;
    state_next.irq_dog      = 1'b0;
    state_next.core_wake    = 1'b0;
    state_next.sys_rst_req  = 1'b0;

    // capture write address and data in either order
    if (aw_fire) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = AXI_REQ_I.awaddr;
    end
    if (w_fire) begin
      state_next.w_held = 1'b1;
      state_next.w_data = AXI_REQ_I.wdata;
      state_next.w_strb = AXI_REQ_I.wstrb;
    end
    // write response retires on bready
    if (state_reg.bvalid && AXI_REQ_I.bready) begin
      state_next.bvalid = 1'b0;
    end
    // read response retires on rready
    if (state_reg.rvalid && AXI_REQ_I.rready) begin
      state_next.rvalid = 1'b0;
    end

    // interval timer: counts in the core domain, so any read is coherent
    state_next.tick_prev = TICK_SRC_I;
    if (state_reg.ctl[iwt_pkg::CTL_RUN] && sel_edge) begin // R1 R2
      if (state_reg.presc >= div_last) begin // R5
        state_next.presc = 8'h00;
        if (state_reg.count == 16'hFFFF) begin
          // wrap: reload the negative value or run on from zero
          state_next.count = state_reg.ctl[iwt_pkg::CTL_RELOAD] ?
                             state_reg.reload : 16'h0000; // R3 R10
          if (state_reg.ctl[iwt_pkg::CTL_IRQ]) begin
            state_next.irq_interval = 1'b1; // R6
          end
        end else begin
          state_next.count = state_reg.count + 16'h0001; // R1
        end
      end else begin
        state_next.presc = state_reg.presc + 8'h01;
      end
    end

    // mantissa zero keeps the counter parked
    // wake-up timer on slow rc edges; a zero mantissa stops it
    state_next.slow_prev = SLOW_RC_CLOCK_I;
    if (state_reg.wake_code[7:4] == 4'h0) begin
      state_next.wake_cnt = '0;
    end else if (SLOW_RC_CLOCK_I && !state_reg.slow_prev) begin
      if (state_reg.wake_cnt >= wake_period - iwt_pkg::WAKE_CW'(1)) begin // R12
        state_next.wake_cnt  = '0;
        state_next.core_wake = 1'b1; // R13
      end else begin
        state_next.wake_cnt = state_reg.wake_cnt + iwt_pkg::WAKE_CW'(1);
      end
    end

    // counts without pause once armed;
    // a good clear or a reset zeroes it
    // watchdog counts system clocks once armed
    if (state_reg.dog_arm) begin
      if (state_reg.dog_cnt >= dog_last) begin
        state_next.dog_cnt = 32'h0000_0000; // R14
        dog_fire = 1'b1;
      end else begin
        state_next.dog_cnt = state_reg.dog_cnt + 32'h0000_0001;
      end
    end

    // a pending first clear word is dropped by any other access
    if (state_reg.kick_st == iwt_pkg::KICK_HALF &&
        ((wr_do && wsel != iwt_pkg::REG_KICK) || ar_fire)) begin
      state_next.kick_st = iwt_pkg::KICK_IDLE;
    end

    // register write, done once both halves are held
    if (wr_do) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = iwt_pkg::RESP_OKAY;
      unique case (wsel)
        iwt_pkg::REG_WAKE: begin
          wval = merge({24'h00_0000, state_reg.wake_code}, state_reg.w_data,
                       state_reg.w_strb);
          state_next.wake_code = wval[7:0];
          state_next.wake_cnt  = '0; // new period starts afresh
        end
        iwt_pkg::REG_COUNT: begin
          // writing while running may lose a tick in flight
          wval = merge({16'h0000, state_reg.count}, state_reg.w_data, state_reg.w_strb);
          state_next.count = wval[15:0]; // R8
        end
        iwt_pkg::REG_RELOAD: begin
          wval = merge({16'h0000, state_reg.reload}, state_reg.w_data, state_reg.w_strb);
          state_next.reload = wval[15:0]; // R10
        end
        iwt_pkg::REG_CTL: begin
          wval = merge({24'h00_0000, state_reg.ctl}, state_reg.w_data, state_reg.w_strb);
          state_next.ctl = {1'b0, wval[6:0]}; // R9
        end
        iwt_pkg::REG_DOG: begin
          wval = merge({27'h000_0000, state_reg.dog_timeout_sel, state_reg.dog_caused_reset,
                        state_reg.dog_reset_arm, state_reg.dog_arm},
                       state_reg.w_data, state_reg.w_strb);
          // enable and reset-arm only ever set from software
          state_next.dog_arm       = state_reg.dog_arm | wval[iwt_pkg::DOG_ARM_BIT]; // R16
          state_next.dog_reset_arm = state_reg.dog_reset_arm |
                                     wval[iwt_pkg::DOG_RST_BIT]; // R15
          // flag cleared by writing zero
          state_next.dog_caused_reset = state_reg.dog_caused_reset &
                                        wval[iwt_pkg::DOG_FLAG_BIT]; // R18
          state_next.dog_timeout_sel = wval[iwt_pkg::DOG_SEL_LO +: 2]; // R17
        end
        iwt_pkg::REG_KICK: begin
          wval = merge(state_reg.kick_last, state_reg.w_data, state_reg.w_strb);
          state_next.kick_last = wval;
          unique case (state_reg.kick_st)
            iwt_pkg::KICK_IDLE: begin
              if (wval == iwt_pkg::KICK_WORD_FIRST) begin
                state_next.kick_st = iwt_pkg::KICK_HALF; // R19
              end else begin
                dog_fire = state_reg.dog_arm; // R20
              end
            end
            iwt_pkg::KICK_HALF: begin
              state_next.kick_st = iwt_pkg::KICK_IDLE;
              if (wval == iwt_pkg::KICK_WORD_SECOND) begin
                state_next.dog_cnt = 32'h0000_0000; // R21
              end else begin
                dog_fire = state_reg.dog_arm; // R20
              end
            end
          endcase
        end
        default: begin
          state_next.bresp = iwt_pkg::RESP_SLVERR; // unmapped, nothing stored
        end
      endcase
    end

    // a watchdog event resets the system or interrupts by mode
    if (dog_fire) begin
      if (state_reg.dog_reset_arm) begin
        state_next.sys_rst_req = 1'b1; // R15
      end else begin
        state_next.irq_dog = 1'b1; // R14 R20
      end
    end

    // wake from a wrap needs the irq allowed
    // interval interrupt also wakes the core from halt
    if (state_next.irq_interval) begin
      state_next.core_wake = 1'b1; // R6
    end

    // a read only cancels a pending
    // first clear word
    // register read, answered one edge after the address is taken
    if (ar_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = iwt_pkg::RESP_OKAY;
      unique case (rsel)
        iwt_pkg::REG_WAKE:   state_next.rdata = {24'h00_0000, state_reg.wake_code};
        iwt_pkg::REG_COUNT:  state_next.rdata = {16'h0000, state_reg.count}; // R7
        iwt_pkg::REG_RELOAD: state_next.rdata = {16'h0000, state_reg.reload};
        iwt_pkg::REG_CTL:    state_next.rdata = {24'h00_0000, state_reg.ctl};
        iwt_pkg::REG_DOG: begin
          state_next.rdata = {27'h000_0000, state_reg.dog_timeout_sel,
                              state_reg.dog_caused_reset, state_reg.dog_reset_arm,
                              state_reg.dog_arm};
        end
        iwt_pkg::REG_KICK:   state_next.rdata = state_reg.kick_last;
        default: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = iwt_pkg::RESP_SLVERR;
        end
      endcase
    end

    // first edge after reset release catches the reset cause; set beats a clear
    if (!state_reg.init_done) begin
      state_next.init_done = 1'b1;
      if (DOG_RESET_CAUSE_I) begin
        state_next.dog_caused_reset = 1'b1; // R18
      end
    end
  end

  // one register for all state: a reset
  // leaves no timer half cleared
  // state register; reset zeroes every counter, the watchdog one included
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= iwt_pkg::STATE_RST; // R21
    end else begin
      state_reg <= state_next;
    end
  end

  // unused interrupt lines stay low
  // outputs; pulses and data come straight from the state register
  always_comb begin
    AXI_RSP_O.awready = aw_ready;
    AXI_RSP_O.wready  = w_ready;
    AXI_RSP_O.bvalid  = state_reg.bvalid;
    AXI_RSP_O.bresp   = state_reg.bresp;
    AXI_RSP_O.arready = ar_ready;
    AXI_RSP_O.rvalid  = state_reg.rvalid;
    AXI_RSP_O.rdata   = state_reg.rdata;
    AXI_RSP_O.rresp   = state_reg.rresp;
    IRQ_LINES_O = 32'h0000_0000;
    IRQ_LINES_O[iwt_pkg::IRQ_LINE_INTERVAL] = state_reg.irq_interval; // R11
    IRQ_LINES_O[iwt_pkg::IRQ_LINE_DOG]      = state_reg.irq_dog;
    CORE_WAKE_O     = state_reg.core_wake;
    SYS_RESET_REQ_O = state_reg.sys_rst_req;
  end

endmodule

// File: design/iwt_pkg.sv
// constants, register map and carrier types for the interval, wake and watchdog timers
package iwt_pkg;

  // axi4-lite widths; printed offsets are register indices, byte address is index * 4
  localparam int AXI_AW = 34;
  localparam int AXI_DW = 32;

  // register indices as printed
  localparam logic [31:0] IDX_WAKE   = 32'h5000_0004;
  localparam logic [31:0] IDX_COUNT  = 32'h5000_0070;
  localparam logic [31:0] IDX_RELOAD = 32'h5000_0072;
  localparam logic [31:0] IDX_CTL    = 32'h5000_0074;
  localparam logic [31:0] IDX_DOG    = 32'h5002_0018;
  localparam logic [31:0] IDX_KICK   = 32'h5002_001C;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // interval control field positions
  localparam int CTL_RUN    = 0;
  localparam int CTL_RELOAD = 1;
  localparam int CTL_SRC_LO = 2;
  localparam int CTL_DIV_LO = 4;
  localparam int CTL_IRQ    = 6;

  // watchdog control field positions
  localparam int DOG_ARM_BIT  = 0;
  localparam int DOG_RST_BIT  = 1;
  localparam int DOG_FLAG_BIT = 2;
  localparam int DOG_SEL_LO   = 3;

  // reset values
  localparam logic [7:0]  CTL_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [7:0]  WAKE_RST   = 8'h00;
  localparam logic [31:0] KICK_RST   = 32'h0000_0000;

  // watchdog clear words
  localparam logic [31:0] KICK_WORD_FIRST  = 32'h3C57_0001;
  localparam logic [31:0] KICK_WORD_SECOND = 32'h007F_4AD6;

  // watchdog timeouts in system clocks
  localparam logic [32:0] DOG_TMO_CYC_0 = 33'h0_0000_2000;
  localparam logic [32:0] DOG_TMO_CYC_1 = 33'h0_0008_0000;
  localparam logic [32:0] DOG_TMO_CYC_2 = 33'h0_0040_0000;
  localparam logic [32:0] DOG_TMO_CYC_3 = 33'h1_0000_0000;

  // prescaler terminal counts for divide by 1, 4, 16, 256
  localparam logic [7:0] PRESC_LAST_1   = 8'h00;
  localparam logic [7:0] PRESC_LAST_4   = 8'h03;
  localparam logic [7:0] PRESC_LAST_16  = 8'h0F;
  localparam logic [7:0] PRESC_LAST_256 = 8'hFF;

  // wake timer
  localparam logic [3:0] WAKE_EXP_MAX = 4'hC;
  localparam int         WAKE_CW      = 20;

  // interrupt line numbers
  localparam int IRQ_LINE_INTERVAL = 14;
  localparam int IRQ_LINE_DOG      = 19;

  // register selector
  typedef enum logic [2:0] {
    REG_NONE, REG_WAKE, REG_COUNT, REG_RELOAD, REG_CTL, REG_DOG, REG_KICK
  } iwt_reg_t;

  // clear-sequence progress
  typedef enum logic {
    KICK_IDLE = 1'b0,
    KICK_HALF = 1'b1
  } iwt_kick_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [AXI_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } iwt_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } iwt_axi_rsp_t;

  // tick sources, aux in bit 0 so the select code indexes them
  typedef struct packed {
    logic pll;
    logic rc;
    logic xtal;
    logic aux;
  } iwt_ticks_t;

  // whole state of the block
  typedef struct packed {
    logic              aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_held;
    logic [AXI_DW-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctl;
    logic [15:0]       count;
    logic [15:0]       reload;
    logic [7:0]        presc;
    logic [3:0]        tick_prev;
    logic [7:0]        wake_code;
    logic [WAKE_CW-1:0] wake_cnt;
    logic              slow_prev;
    logic              dog_arm;
    logic              dog_reset_arm;
    logic              dog_caused_reset;
    logic [1:0]        dog_timeout_sel;
    logic [31:0]       dog_cnt;
    logic [31:0]       kick_last;
    iwt_kick_t         kick_st;
    logic              init_done;
    logic              irq_interval;
    logic              irq_dog;
    logic              core_wake;
    logic              sys_rst_req;
  } iwt_state_t;

  // every field resets to zero, matching the register reset values
  localparam iwt_state_t STATE_RST = '0;

endpackage

// File: testbench/iwt_timers_monitor.sv
// port assertions for the interval, wake and watchdog timer block
`timescale 1ns/10ps
module iwt_timers_monitor (
  input wire logic                  CORE_CLK_I,
  input wire logic                  ARST_N_I,
  input wire iwt_pkg::iwt_axi_req_t AXI_REQ_I,
  input wire iwt_pkg::iwt_axi_rsp_t AXI_RSP_O,
  input wire logic [31:0]           IRQ_LINES_O,
  input wire logic                  CORE_WAKE_O,
  input wire logic                  SYS_RESET_REQ_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // both write halves taken at one edge
  sequence s_wr_take;
    AXI_REQ_I.awvalid && AXI_RSP_O.awready && AXI_REQ_I.wvalid && AXI_RSP_O.wready;
  endsequence
  // answer comes one or two edges later
  sequence s_wr_resp;
    ##[1:2] AXI_RSP_O.bvalid;
  endsequence
  chk_write_resp:
    assert property (s_wr_take |-> s_wr_resp) else $error("write answer late");
  chk_bresp_hold:
    assert property (AXI_RSP_O.bvalid && !AXI_REQ_I.bready |=>
      AXI_RSP_O.bvalid && $stable(AXI_RSP_O.bresp)) else $error("write answer dropped");
  chk_read_resp:
    assert property (AXI_REQ_I.arvalid && AXI_RSP_O.arready |=> AXI_RSP_O.rvalid)
      else $error("read answer late");
  chk_rdata_hold:
    assert property (AXI_RSP_O.rvalid && !AXI_REQ_I.rready |=>
      AXI_RSP_O.rvalid && $stable(AXI_RSP_O.rdata)) else $error("read data moved");
  chk_line_map:
    assert property ((IRQ_LINES_O & ~32'h0008_4000) == 32'h0000_0000)
      else $error("stray interrupt line");
  chk_wrap_wake:
    assert property (IRQ_LINES_O[14] |-> CORE_WAKE_O) else $error("wrap without wake");
  chk_wrap_pulse:
    assert property (IRQ_LINES_O[14] |=> !IRQ_LINES_O[14]) else $error("wrap pulse long");
  chk_reset_mode:
    assert property (SYS_RESET_REQ_O |-> !IRQ_LINES_O[19]) else $error("reset and irq both");
  chk_dog_pulse:
    assert property ((SYS_RESET_REQ_O || IRQ_LINES_O[19]) |=>
      !SYS_RESET_REQ_O && !IRQ_LINES_O[19]) else $error("watchdog pulse long");
endmodule
bind iwt_timers iwt_timers_monitor i_mon (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I),
  .AXI_REQ_I(AXI_REQ_I), .AXI_RSP_O(AXI_RSP_O), .IRQ_LINES_O(IRQ_LINES_O),
  .CORE_WAKE_O(CORE_WAKE_O), .SYS_RESET_REQ_O(SYS_RESET_REQ_O));

// File: testbench/iwt_timers_tb_top.sv
// self-checking bench for the timer block over its register bus
`timescale 1ns/10ps
module iwt_timers_tb_top;
  localparam logic [31:0] WK = iwt_pkg::IDX_WAKE;
  localparam logic [31:0] CN = iwt_pkg::IDX_COUNT;
  localparam logic [31:0] RL = iwt_pkg::IDX_RELOAD;
  localparam logic [31:0] CT = iwt_pkg::IDX_CTL;
  localparam logic [31:0] DG = iwt_pkg::IDX_DOG;
  localparam logic [31:0] KK = iwt_pkg::IDX_KICK;
  logic                  clk, arst_n, cause, sl; // clock, reset, cause, slow rc
  iwt_pkg::iwt_ticks_t   ts;                     // tick source levels
  iwt_pkg::iwt_axi_req_t rq;                     // bus request
  iwt_pkg::iwt_axi_rsp_t rs;                     // bus answer
  logic [31:0]           irq, d;                 // lines, read data
  logic                  wake, srst;             // wake and reset pulses
  logic [1:0]            r;                      // read response
  int bad_count = 0, compares = 0, cyc = 0, ni = 0, nd = 0, nw = 0, nr = 0, n, c;
  int dv[4] = '{1, 4, 16, 256};                  // divisor per code
  int tm[4] = '{16, 32, 64, 128};                // shortened timeouts
  logic [31:0] bk[2] = '{32'h1234_5678, iwt_pkg::KICK_WORD_SECOND}; // bad kicks
  // short timeouts keep the run small
  iwt_timers #(.DOG_TMO_0(33'h0_0000_0010), .DOG_TMO_1(33'h0_0000_0020),
    .DOG_TMO_2(33'h0_0000_0040), .DOG_TMO_3(33'h0_0000_0080)) i_dut (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .AXI_REQ_I(rq), .AXI_RSP_O(rs),
    .TICK_SRC_I(ts), .SLOW_RC_CLOCK_I(sl), .DOG_RESET_CAUSE_I(cause),
    .IRQ_LINES_O(irq), .CORE_WAKE_O(wake), .SYS_RESET_REQ_O(srst));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulse counters and hang guard; nonblocking so reads never race
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ni <= ni + int'(irq[14]);
    nd <= nd + int'(irq[19]);
    nw <= nw + int'(wake);
    nr <= nr + int'(srst);
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: halves released as taken, bready raised late to stall
  task automatic wr(input logic [31:0] ix, input logic [31:0] v);
    logic a, w;
    @(posedge clk);
    a = 1'b1;
    w = 1'b1;
    rq.awaddr <= {ix, 2'b00};
    rq.wdata <= v;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && rs.awready) rq.awvalid <= 1'b0;
      if (w && rs.wready) rq.wvalid <= 1'b0;
      a = a & !rs.awready;
      w = w & !rs.wready;
    end
    repeat (2) @(posedge clk);
    rq.bready <= 1'b1;
    do @(posedge clk); while (!rs.bvalid);
    rq.bready <= 1'b0;
  endtask
  // read: rready raised one edge late to stall the answer
  task automatic rd(input logic [31:0] ix);
    @(posedge clk);
    rq.araddr <= {ix, 2'b00};
    rq.arvalid <= 1'b1;
    do @(posedge clk); while (!rs.arready);
    rq.arvalid <= 1'b0;
    @(posedge clk);
    rq.rready <= 1'b1;
    do @(posedge clk); while (!rs.rvalid);
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [31:0] ix, input logic [31:0] e);
    rd(ix);
    ck(nm, e, d);
  endtask
  // k rising edges on the masked sources, two cycles high, two low
  task automatic tk(input logic [4:0] m, input int k);
    repeat (k) begin
      @(posedge clk);
      {sl, ts} <= {sl, ts} | m;
      repeat (2) @(posedge clk);
      {sl, ts} <= {sl, ts} & ~m;
      @(posedge clk);
    end
  endtask
  task automatic kick();
    wr(KK, iwt_pkg::KICK_WORD_FIRST);
    wr(KK, iwt_pkg::KICK_WORD_SECOND);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    cause = 1'b0;
    sl = 1'b0;
    ts = '0;
    rq = '0;
    rq.wstrb = 4'hF;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (tm[i]) rc("reset value", i[0] ? CN : (i[1] ? DG : WK), 32'h0);
    rc("reset ctl", CT, 32'h0);
    rd(32'h5000_0008);
    ck("unmapped resp", 32'(iwt_pkg::RESP_SLVERR), 32'(r));
    wr(RL, 32'hFFFF_ABCD);
    rc("reload width", RL, 32'h0000_ABCD);
    wr(CT, 32'h80);
    rc("ctl reserved", CT, 32'h0);
    // each source with its own divisor code
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'h0);
      wr(CN, 32'h0);
      wr(CT, 32'(1 + 20 * i));
      tk(5'(1 << i), 2 * dv[i]);
      rc("count per tick", CN, 32'h2);
    end
    wr(CT, 32'h0C);
    tk(5'h08, 3);
    rc("frozen count", CN, 32'h2);
    wr(CT, 32'h0D);
    tk(5'h08, 1);
    rc("resumed count", CN, 32'h3);
    // wrap with and without reload, then with the interrupt off
    wr(CT, 32'h0);
    wr(RL, 32'hFFFD);
    wr(CN, 32'hFFFF);
    n = ni;
    c = nw;
    wr(CT, 32'h47);
    tk(5'h02, 2);
    rc("reloaded count", CN, 32'hFFFE);
    ck("wrap irq", n + 1, ni);
    ck("wrap wake", c + 1, nw);
    wr(CT, 32'h45);
    tk(5'h02, 2);
    rc("wrap to zero", CN, 32'h0);
    wr(CT, 32'h0);
    wr(CN, 32'hFFFF);
    wr(CT, 32'h05);
    tk(5'h02, 1);
    ck("irq masked", n + 2, ni);
    ck("wake masked", c + 2, nw);
    // mantissa 2, exponent 1: 64 slow edges
    wr(WK, 32'h21);
    tk(5'h10, 63);
    ck("wake early", c + 2, nw);
    tk(5'h10, 1);
    ck("wake expiry", c + 3, nw);
    wr(WK, 32'h0);
    // timeout per select code, measured from a good clear
    for (int i = 0; i < 4; i++) begin
      wr(DG, 32'(1 + 8 * i));
      kick();
      c = 0;
      while (!irq[19] && c < 300) begin
        @(posedge clk);
        c++;
      end
      ck("dog period", 1, 32'(c >= tm[i] - 4 && c <= tm[i] + 1));
    end
    wr(DG, 32'h18);
    rc("arm sticky", DG, 32'h19);
    foreach (bk[i]) begin
      kick();
      n = nd;
      wr(KK, bk[i]);
      repeat (3) @(posedge clk);
      ck("bad kick", n + 1, nd);
    end
    wr(DG, 32'h1A);
    kick();
    n = nd;
    c = nr;
    wr(KK, 32'h0);
    repeat (3) @(posedge clk);
    ck("reset request", c + 1, nr);
    ck("no irq in reset mode", n, nd);
    wr(DG, 32'h19);
    rc("reset arm sticky", DG, 32'h1B);
    @(posedge clk);
    arst_n <= 1'b0;
    cause <= 1'b1;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rc("cause flag", DG, 32'h04);
    cause <= 1'b0;
    wr(DG, 32'h0);
    rc("flag cleared", DG, 32'h0);
    rc("reload after reset", RL, 32'h0);
    tally_and_finish();
  end
endmodule
